/* File: common/imager_ctrl_pkg.sv */
/*
 * Shared constants and types for the imager mode, pause and gain-select logic.
 * Assumes one system clock and an 8-bit register port with reads answered one cycle later.
 */
// Function
// - Master with hold bit waits hold-low before readout
// - Hold bit 0 reads at once, 1 pauses
// - Role select low is master, high slave
// - Master drives row and column address outputs
// - Four select pins form gain/offset table code in slave; master takes it from the ctrl0 register
// - After reset gain unity, offset zero
// - Reset low returns control state to defaults
`default_nettype none

package imager_ctrl_pkg;

    // ----------------------------------------------------------------
    // Array geometry and register port widths
    // ----------------------------------------------------------------
    localparam int ROW_W = 11;
    localparam int COL_W = 11;
    localparam int ROWS = 1026;
    localparam int COLS = 1026;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int CODE_W = 4;

    // ----------------------------------------------------------------
    // Register indexes and fields
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] REG_CTRL0_ADDR = 4'h0;
    localparam logic [ADDR_W-1:0] REG_CTRL1_ADDR = 4'h1;
    localparam logic [ADDR_W-1:0] REG_STATUS_ADDR = 4'h2;
    localparam int CTRL1_RUN_BIT = 0;
    localparam int CTRL1_HOLD_BIT = 7;
    localparam logic [DATA_W-1:0] CTRL1_RESET = 8'h01;
    localparam logic [CODE_W-1:0] CODE_UNITY = 4'h0;
    localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_XFER, ST_WAIT, ST_READ} scan_e;

    typedef struct packed {
        logic role;
        logic hold;
        logic [CODE_W-1:0] code;
        logic [ROW_W-1:0] row;
        logic [COL_W-1:0] col;
    } pins_s;

    typedef struct packed {
        scan_e st;
        logic [ROW_W-1:0] row;
        logic [COL_W-1:0] col;
        logic drive;
        logic [CODE_W-1:0] code;
        logic [CODE_W-1:0] ctrl0;
        logic [DATA_W-1:0] ctrl1;
        logic xfer;
        logic busy;
        logic [DATA_W-1:0] rdata;
    } core_s;

endpackage

`default_nettype wire

/* File: design/pin_sync.sv */
/*
 * Two-stage synchroniser for a vector of pin levels.
 * Assumes each bit is a level that stays put for several clocks; a multi-bit bus
 * must be held stable by its driver, since bits may land one cycle apart.
 */
`default_nettype none

module pin_sync #(
    parameter int W = 8
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [W-1:0] din_in,
    output logic [W-1:0] dout_out
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_s;

    sync_s r;
    sync_s nxt;

    // ----------------------------------------------------------------
    // Two flops; the first is read only by the second
    // ----------------------------------------------------------------
    always_comb begin
        nxt = r;
        nxt.s1 = din_in;
        nxt.s2 = r.s1;
    end

    // Flop stage
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            r <= '0;
        end else begin
            r <= nxt;
        end
    end

    assign dout_out = r.s2;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_sync_high;
        @(posedge clk_in) disable iff (!rst_n_in)
        din_in[0] [*3] |-> dout_out[0];
    endproperty
    a_sync_high: assert property (p_sync_high) else $error("sync did not pass a high level");

    property p_sync_low;
        @(posedge clk_in) disable iff (!rst_n_in)
        (!din_in[0]) [*3] |-> !dout_out[0];
    endproperty
    a_sync_low: assert property (p_sync_low) else $error("sync did not pass a low level");

endmodule // pin_sync

`default_nettype wire

/* File: design/imager_mode_pause_gain_select.sv */
/*
 * Readout controller core: master/slave role, transfer and pause sequencing,
 * pixel address scan or pickup, and gain/offset code selection.
 * Assumes all pins are asynchronous levels and the register port shares the clock.
 */
// Chosen here: the plain strobed port and the placing of the registers.
`default_nettype none

module imager_mode_pause_gain_select #(
    parameter int ROWS = imager_ctrl_pkg::ROWS,
    parameter int COLS = imager_ctrl_pkg::COLS
) (
    input wire logic CLK_SYS_IN,
    input wire logic RST_N_IN,
    input wire logic ROLE_SLAVE_IN,
    input wire logic HOLD_N_IN,
    input wire logic AMP_SELECT_HI_IN,
    input wire logic AMP_SELECT_LO_IN,
    input wire logic LEVEL_SHIFT_HI_IN,
    input wire logic LEVEL_SHIFT_LO_IN,
    input wire logic [imager_ctrl_pkg::ROW_W-1:0] ROW_ADDR_IN,
    input wire logic [imager_ctrl_pkg::COL_W-1:0] COL_ADDR_IN,
    input wire logic [imager_ctrl_pkg::ADDR_W-1:0] REG_ADDR_IN,
    input wire logic [imager_ctrl_pkg::DATA_W-1:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    output logic [imager_ctrl_pkg::ROW_W-1:0] ROW_ADDR_OUT,
    output logic ROW_ADDR_OE_OUT,
    output logic [imager_ctrl_pkg::COL_W-1:0] COL_ADDR_OUT,
    output logic COL_ADDR_OE_OUT,
    output logic [imager_ctrl_pkg::CODE_W-1:0] GAIN_CODE_OUT,
    output logic TRANSFER_OUT,
    output logic READOUT_OUT,
    output logic [imager_ctrl_pkg::DATA_W-1:0] REG_RDATA_OUT
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    localparam logic [imager_ctrl_pkg::ROW_W-1:0] ROW_LAST = imager_ctrl_pkg::ROW_W'(ROWS - 1);
    localparam logic [imager_ctrl_pkg::COL_W-1:0] COL_LAST = imager_ctrl_pkg::COL_W'(COLS - 1);

    imager_ctrl_pkg::pins_s pins_raw;
    imager_ctrl_pkg::pins_s pins;
    imager_ctrl_pkg::core_s r;
    imager_ctrl_pkg::core_s nxt;
    logic master;
    logic hold_en;

    // Pin code order: amp hi, amp lo, shift hi, shift lo
    always_comb begin
        pins_raw.role = ROLE_SLAVE_IN;
        pins_raw.hold = HOLD_N_IN;
        pins_raw.code = {AMP_SELECT_HI_IN, AMP_SELECT_LO_IN, LEVEL_SHIFT_HI_IN, LEVEL_SHIFT_LO_IN};
        pins_raw.row = ROW_ADDR_IN;
        pins_raw.col = COL_ADDR_IN;
    end

    // Every pin goes through the same two-flop stage
    pin_sync #(
        .W($bits(imager_ctrl_pkg::pins_s))
    ) u_sync (
        .clk_in(CLK_SYS_IN),
        .rst_n_in(RST_N_IN),
        .din_in(pins_raw),
        .dout_out(pins)
    );

    assign master = !pins.role;
    assign hold_en = r.ctrl1[imager_ctrl_pkg::CTRL1_HOLD_BIT];

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------

    // Scan sequencer, register writes and read answer
    always_comb begin
        nxt = r;
        nxt.xfer = 1'b0;
        nxt.drive = master;
        nxt.busy = 1'b0;

        // Sequencer; slave mode parks it in idle
        case (r.st)
            imager_ctrl_pkg::ST_IDLE: begin
                if (master && r.ctrl1[imager_ctrl_pkg::CTRL1_RUN_BIT]) begin
                    nxt.st = imager_ctrl_pkg::ST_XFER;
                    nxt.xfer = 1'b1;
                end
            end
            imager_ctrl_pkg::ST_XFER: begin
                if (!master) begin
                    nxt.st = imager_ctrl_pkg::ST_IDLE;
                end else if (hold_en) begin
                    nxt.st = imager_ctrl_pkg::ST_WAIT;
                end else begin
                    nxt.st = imager_ctrl_pkg::ST_READ;
                    nxt.row = '0;
                    nxt.col = '0;
                    nxt.busy = 1'b1;
                end
            end
            imager_ctrl_pkg::ST_WAIT: begin
                // Only the synchronised copy is read, so a slow edge cannot split the decision
                if (!master) begin
                    nxt.st = imager_ctrl_pkg::ST_IDLE;
                end else if (!pins.hold) begin
                    nxt.st = imager_ctrl_pkg::ST_READ;
                    nxt.row = '0;
                    nxt.col = '0;
                    nxt.busy = 1'b1;
                end
            end
            imager_ctrl_pkg::ST_READ: begin
                nxt.busy = 1'b1;
                if (!master) begin
                    nxt.st = imager_ctrl_pkg::ST_IDLE;
                    nxt.busy = 1'b0;
                end else if (r.col != COL_LAST) begin
                    nxt.col = r.col + 1'b1;
                end else if (r.row != ROW_LAST) begin
                    nxt.col = '0;
                    nxt.row = r.row + 1'b1;
                end else begin
                    nxt.st = imager_ctrl_pkg::ST_IDLE;
                    nxt.busy = 1'b0;
                end
            end
            default: begin
                nxt.st = imager_ctrl_pkg::ST_IDLE;
            end
        endcase

        // Slave: address comes from the outside bus, held stable by its driver
        if (!master) begin
            nxt.row = pins.row;
            nxt.col = pins.col;
        end

        // Code source: register in master, pins in slave
        if (master) begin
            nxt.code = r.ctrl0;
        end else begin
            nxt.code = pins.code;
        end

        // Register writes
        if (REG_WR_IN) begin
            if (REG_ADDR_IN == imager_ctrl_pkg::REG_CTRL0_ADDR) begin
                nxt.ctrl0 = REG_WDATA_IN[imager_ctrl_pkg::CODE_W-1:0];
            end else if (REG_ADDR_IN == imager_ctrl_pkg::REG_CTRL1_ADDR) begin
                nxt.ctrl1 = REG_WDATA_IN;
            end
        end

        // Read answer stands one cycle only; unmapped reads give zero
        nxt.rdata = imager_ctrl_pkg::DATA_ZERO;
        if (REG_RD_IN) begin
            if (REG_ADDR_IN == imager_ctrl_pkg::REG_CTRL0_ADDR) begin
                nxt.rdata = {{(imager_ctrl_pkg::DATA_W - imager_ctrl_pkg::CODE_W){1'b0}}, r.ctrl0};
            end else if (REG_ADDR_IN == imager_ctrl_pkg::REG_CTRL1_ADDR) begin
                nxt.rdata = r.ctrl1;
            end else if (REG_ADDR_IN == imager_ctrl_pkg::REG_STATUS_ADDR) begin
                nxt.rdata = {r.code, r.busy, pins.hold, r.st == imager_ctrl_pkg::ST_WAIT, !master};
            end
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------

    // Reset puts the sequencer idle, unity gain, run enabled
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            r <= '0;
            r.code <= imager_ctrl_pkg::CODE_UNITY;
            r.ctrl0 <= imager_ctrl_pkg::CODE_UNITY;
            r.ctrl1 <= imager_ctrl_pkg::CTRL1_RESET;
            r.st <= imager_ctrl_pkg::ST_IDLE;
        end else begin
            r <= nxt;
        end
    end

    // Outputs straight from the state flops
    assign ROW_ADDR_OUT = r.row;
    assign COL_ADDR_OUT = r.col;
    assign ROW_ADDR_OE_OUT = r.drive;
    assign COL_ADDR_OE_OUT = r.drive;
    assign GAIN_CODE_OUT = r.code;
    assign TRANSFER_OUT = r.xfer;
    assign READOUT_OUT = r.busy;
    assign REG_RDATA_OUT = r.rdata;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_hold_blocks;
        @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        (r.st == imager_ctrl_pkg::ST_WAIT && master && pins.hold) |=> (r.st == imager_ctrl_pkg::ST_WAIT && !READOUT_OUT);
    endproperty
    a_hold_blocks: assert property (p_hold_blocks) else $error("readout left pause while hold high");

    property p_hold_release;
        @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        (r.st == imager_ctrl_pkg::ST_WAIT && master && !pins.hold) |=> READOUT_OUT ##1 READOUT_OUT;
    endproperty
    a_hold_release: assert property (p_hold_release) else $error("readout did not start on hold low");

    property p_bit_mode;
        @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        (TRANSFER_OUT && master && !hold_en) |=> (r.st == imager_ctrl_pkg::ST_READ && ROW_ADDR_OUT == '0);
    endproperty
    a_bit_mode: assert property (p_bit_mode) else $error("no immediate readout with hold bit clear");

    property p_role;
        @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        1'b1 |=> (ROW_ADDR_OE_OUT == !$past(pins.role) && COL_ADDR_OE_OUT == ROW_ADDR_OE_OUT);
    endproperty
    a_role: assert property (p_role) else $error("address drive does not follow role");

    property p_scan_step;
        @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        (r.st == imager_ctrl_pkg::ST_READ && master && r.col != COL_LAST) |=> COL_ADDR_OUT == $past(COL_ADDR_OUT) + 1'b1;
    endproperty
    a_scan_step: assert property (p_scan_step) else $error("column address did not advance");

    property p_code_pins;
        @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        pins.role |=> GAIN_CODE_OUT == $past(pins.code);
    endproperty
    a_code_pins: assert property (p_code_pins) else $error("slave code does not follow pins");

    property p_unity;
        @(posedge CLK_SYS_IN)
        $rose(RST_N_IN) |-> (GAIN_CODE_OUT == imager_ctrl_pkg::CODE_UNITY);
    endproperty
    a_unity: assert property (p_unity) else $error("gain code not unity after reset");

    property p_reset;
        @(posedge CLK_SYS_IN)
        !RST_N_IN |-> (r.st == imager_ctrl_pkg::ST_IDLE && !TRANSFER_OUT && !READOUT_OUT);
    endproperty
    a_reset: assert property (p_reset) else $error("control state not default in reset");

endmodule // imager_mode_pause_gain_select

`default_nettype wire

/* File: verification/ext_controller.sv */
/*
 * Model of the outside camera controller: role, hold and code pins, and the
 * address buses while the device is a slave.
 * Assumes the bench hands it commands and that it shares the device clock.
 */
`default_nettype none

module ext_controller (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic role_cmd_in,
    input wire logic [3:0] code_cmd_in,
    input wire logic [10:0] row_cmd_in,
    input wire logic [10:0] col_cmd_in,
    input wire logic [7:0] hold_dly_in,
    input wire logic xfer_in,
    input wire logic read_in,
    input wire logic row_oe_in,
    input wire logic col_oe_in,
    input wire logic [10:0] row_dev_in,
    input wire logic [10:0] col_dev_in,
    output logic role_out,
    output logic hold_n_out,
    output logic [3:0] code_out,
    output logic [10:0] row_out,
    output logic [10:0] col_out
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] cnt_r;
    logic [10:0] row_last_r;
    logic [10:0] col_last_r;

    // ------------------------------------------------------------
    // Bus levels
    // ------------------------------------------------------------
    // Nobody driving shows the inverse of the last level, not a stale copy
    assign row_out = row_oe_in ? row_dev_in : (role_out ? row_cmd_in : ~row_last_r);
    assign col_out = col_oe_in ? col_dev_in : (role_out ? col_cmd_in : ~col_last_r);

    // ------------------------------------------------------------
    // Pin drive and hold timing
    // ------------------------------------------------------------
    // Hold released a set number of cycles after each transfer, raised again at readout
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            role_out <= 1'b0;
            code_out <= 4'h0;
            hold_n_out <= 1'b1;
            cnt_r <= 8'h00;
            row_last_r <= 11'h000;
            col_last_r <= 11'h000;
        end else begin
            role_out <= role_cmd_in;
            code_out <= code_cmd_in;
            row_last_r <= row_out;
            col_last_r <= col_out;
            if (xfer_in) begin
                cnt_r <= hold_dly_in;
                hold_n_out <= (hold_dly_in != 8'h00);
            end else if (cnt_r != 8'h00) begin
                cnt_r <= cnt_r - 8'h01;
                hold_n_out <= (cnt_r != 8'h01);
            end else if (read_in) begin
                hold_n_out <= 1'b1;
            end
        end
    end
endmodule // ext_controller

`default_nettype wire

/* File: verification/imager_mode_pause_gain_select_tb.sv */
/*
 * Self-checking bench for the readout controller core with the outside controller model.
 * Assumes a 4x4 array set by parameter so a frame is short.
 */
`default_nettype none

module imager_mode_pause_gain_select_tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int N_ROWS = 4;
    localparam int N_COLS = 4;
    logic clk, rst_n, role_cmd, role, hold_n, xfer, readout, row_oe, col_oe, reg_wr, reg_rd;
    logic [3:0] code_cmd, pins, gain, reg_addr;
    logic [10:0] row_cmd, col_cmd, row_w, col_w, row_o, col_o;
    logic [7:0] hold_dly, reg_wdata, rdata, rd, w;
    int miscompares, cmp_count, cycles, k;

    // ------------------------------------------------------------
    // Clock, design and partner
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    imager_mode_pause_gain_select #(.ROWS(N_ROWS), .COLS(N_COLS)) dut (.CLK_SYS_IN(clk), .RST_N_IN(rst_n),
        .ROLE_SLAVE_IN(role), .HOLD_N_IN(hold_n), .AMP_SELECT_HI_IN(pins[3]), .AMP_SELECT_LO_IN(pins[2]),
        .LEVEL_SHIFT_HI_IN(pins[1]), .LEVEL_SHIFT_LO_IN(pins[0]), .ROW_ADDR_IN(row_w), .COL_ADDR_IN(col_w),
        .REG_ADDR_IN(reg_addr), .REG_WDATA_IN(reg_wdata), .REG_WR_IN(reg_wr), .REG_RD_IN(reg_rd),
        .ROW_ADDR_OUT(row_o), .ROW_ADDR_OE_OUT(row_oe), .COL_ADDR_OUT(col_o), .COL_ADDR_OE_OUT(col_oe),
        .GAIN_CODE_OUT(gain), .TRANSFER_OUT(xfer), .READOUT_OUT(readout), .REG_RDATA_OUT(rdata));

    ext_controller partner (.clk_in(clk), .rst_n_in(rst_n), .role_cmd_in(role_cmd), .code_cmd_in(code_cmd),
        .row_cmd_in(row_cmd), .col_cmd_in(col_cmd), .hold_dly_in(hold_dly), .xfer_in(xfer),
        .read_in(readout), .row_oe_in(row_oe), .col_oe_in(col_oe), .row_dev_in(row_o), .col_dev_in(col_o),
        .role_out(role), .hold_n_out(hold_n), .code_out(pins), .row_out(row_w), .col_out(col_w));

    // Hang guard, a few thousand cycles is far beyond the planned run
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            test_done();
        end
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [21:0] exp_addr(input int i);
        return {11'(i / N_COLS), 11'(i % N_COLS)};
    endfunction

    task automatic chk_pin(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t pins got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t register got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic reg_wr_t(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic reg_rd_t(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask

    task automatic wait_xfer();
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (xfer !== 1'b1 && k < 200);
        chk_pin({31'h0, xfer}, 32'h1);
    endtask

    task automatic chk_idle();
        chk_pin({row_o, col_o}, 32'h0);
        chk_pin({gain, xfer, readout, row_oe, col_oe, rdata}, 32'h0);
    endtask

    // Called at the first readout cycle; checks the whole scan order
    task automatic scan_check();
        for (int i = 0; i < N_ROWS * N_COLS; i++) begin
            chk_pin({xfer, readout, row_oe, col_oe, row_o, col_o}, {4'b0111, exp_addr(i)});
            @(negedge clk);
        end
        chk_pin({31'h0, readout}, 32'h0);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {role_cmd, code_cmd, row_cmd, col_cmd, hold_dly} = '0;
        {reg_addr, reg_wdata, reg_wr, reg_rd, miscompares, cmp_count, cycles} = '0;
        k = $urandom(95759);
        // Reset falls off the edge, so no flop can miss it before the first clock
        rst_n = 1'b1;
        #1;
        rst_n = 1'b0;
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk_idle();
        @(posedge clk);
        rst_n <= 1'b1;
        reg_rd_t(4'h1, rd);
        chk_reg(rd, 8'h01);
        reg_rd_t(4'hf, rd);
        chk_reg(rd, 8'h00);
        chk_pin(gain, 32'h0);
        wait_xfer();
        @(negedge clk);
        scan_check();
        // Pause: prompt and slow release of the hold pin
        reg_wr_t(4'h1, 8'h81);
        for (int j = 0; j < 3; j++) begin
            @(posedge clk);
            hold_dly <= (j == 0) ? 8'h00 : 8'(3 + $urandom % 28);
            wait_xfer();
            k = 0;
            for (int n = 0; n < 300 && readout !== 1'b1; n++) begin
                @(negedge clk);
                if (readout !== 1'b1 && hold_n === 1'b0) k++;
            end
            chk_pin(k, 32'd3);
            scan_check();
        end
        reg_wr_t(4'h1, 8'h01);
        // Master takes its code from the register
        w = 8'($urandom);
        reg_wr_t(4'h0, w);
        reg_rd_t(4'h0, rd);
        chk_reg(rd, {4'h0, w[3:0]});
        chk_pin(gain, w[3:0]);
        // Slave: every code from the pins, addresses from outside
        @(posedge clk);
        role_cmd <= 1'b1;
        repeat (6) @(negedge clk);
        chk_pin({row_oe, col_oe}, 32'h0);
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            code_cmd <= 4'(i);
            row_cmd <= 11'($urandom);
            col_cmd <= 11'($urandom);
            repeat (5) @(negedge clk);
            chk_pin({readout, gain}, 32'(i));
            chk_pin({row_o, col_o}, {row_cmd, col_cmd});
        end
        // Status in slave: last pin code, idle, hold pin level, slave flag
        reg_rd_t(4'h2, rd);
        chk_reg(rd, {4'hf, 1'b0, hold_n, 2'b01});
        @(posedge clk);
        role_cmd <= 1'b0;
        wait_xfer();
        chk_pin({gain, row_oe, col_oe}, {w[3:0], 2'b11});
        // Reset in mid-frame
        repeat (3) @(negedge clk);
        @(posedge clk);
        rst_n <= 1'b0;
        @(negedge clk);
        chk_idle();
        @(posedge clk);
        rst_n <= 1'b1;
        reg_rd_t(4'h1, rd);
        chk_reg(rd, 8'h01);
        reg_rd_t(4'h0, rd);
        chk_reg(rd, 8'h00);
        chk_pin(gain, 32'h0);
        test_done();
    end

    task automatic test_done();
        $display("miscompares=%0d cmp_count=%0d", miscompares, cmp_count);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
endmodule // imager_mode_pause_gain_select_tb

`default_nettype wire
